// *** inc/lbh_defines.svh ***
// constants for the local bus hold and emulate acknowledge logic
`ifndef LBH_DEFINES_SVH
`define LBH_DEFINES_SVH
`define LBH_PHASE_DIV   1
`define LBH_MEM_CYC     4
`define LBH_WORD_W      16
`define LBH_ACK_RST     1'b1
`define LBH_HOLD_RST    1'b1
`define LBH_STROBE_RST  1'b1
`define LBH_LAD_RST     16'h0000
`define LBH_LAD_PULL    16'hffff
`define LBH_TP_RESET    0
`define LBH_TP_IRQ1     1
`define LBH_TP_IRQ2     2
`define LBH_TP_HSYNC    3
`define LBH_TP_VSYNC    4
`define LBH_TP_W        5
`endif

// *** inc/lbh_pkg.sv ***
// types shared by both ends of the local bus hold link
`include "lbh_defines.svh"
package lbh_pkg;
  typedef logic [`LBH_WORD_W-1:0] lbh_word_t;
  typedef logic [`LBH_TP_W-1:0]   lbh_tpins_t;
  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } lbh_phase_t;
  typedef enum logic [2:0] {
    DS_OWN   = 3'b001,
    DS_REL   = 3'b010,
    DS_GRANT = 3'b100
  } lbh_dstate_t;
  typedef enum logic [3:0] {
    MS_IDLE = 4'b0001,
    MS_REQ  = 4'b0010,
    MS_OWN  = 4'b0100,
    MS_REL  = 4'b1000
  } lbh_mstate_t;
endpackage : lbh_pkg

// *** inc/lbh_if.sv ***
// pins between the graphics device and an external bus master
`timescale 1ns/1ps
`include "lbh_defines.svh"
interface lbh_if;
  import lbh_pkg::*;
  logic      hold_req_n;          // master asks for the bus, low
  logic      shared_ack_out_n;    // grant ack in q3-q4, emulation ack in q1-q2
  logic      local_clock_primary; // high in q1-q2
  logic      local_clock_second;  // high in q2-q3
  lbh_word_t lad_dev;
  logic      lad_dev_oe;
  logic      strobe_dev_n;
  logic      strobe_dev_oe;
  lbh_word_t lad_mst;
  logic      lad_mst_oe;
  logic      strobe_mst_n;
  logic      strobe_mst_oe;
  lbh_word_t lad_bus;
  logic      strobe_bus_n;
  // resolved wire level; undriven bus floats to the pull level
  assign lad_bus      = lad_dev_oe ? lad_dev : (lad_mst_oe ? lad_mst : `LBH_LAD_PULL);
  assign strobe_bus_n = strobe_dev_oe ? strobe_dev_n : (strobe_mst_oe ? strobe_mst_n : 1'b1);
  modport dev (input hold_req_n, lad_bus, strobe_bus_n,
               output shared_ack_out_n, local_clock_primary, local_clock_second,
               output lad_dev, lad_dev_oe, strobe_dev_n, strobe_dev_oe);
  modport mst (output hold_req_n, lad_mst, lad_mst_oe, strobe_mst_n, strobe_mst_oe,
               input shared_ack_out_n, local_clock_primary, local_clock_second, lad_bus, strobe_bus_n);
endinterface : lbh_if

// *** design/lbh_master.sv ***
// external bus master end: requests, owns and returns the local bus
`timescale 1ns/1ps
`include "lbh_defines.svh"
module lbh_master (
  input  wire logic        core_clk_i,   // 40 MHz clock
  input  wire logic        rst_b_i,      // sync reset, low
  lbh_if.mst               bus,          // link to the device
  input  wire logic        want_bus_i,   // user wants the bus, level
  input  wire lbh_pkg::lbh_word_t own_data_i, // word driven while owned
  input  wire logic        own_strobe_i, // strobe request while owned
  output logic             owned_o,      // bus is ours
  output logic             emu_seen_o    // q1-q2 low seen, pulse
);
  import lbh_pkg::*;

  lbh_mstate_t st_r, st_nxt;
  logic        hold_n_r, hold_n_nxt;
  logic        own_r, own_nxt;
  logic        drv_r, drv_nxt;
  lbh_word_t   lad_r, lad_nxt;
  logic        stb_n_r, stb_n_nxt;
  logic        emu_r, emu_nxt;
  logic        ack_q34;

  // q3-q4 is where local_clock_primary is low; emulation lows elsewhere are ignored
  assign ack_q34 = !bus.local_clock_primary && !bus.shared_ack_out_n;

  always_comb begin
    st_nxt     = st_r;
    hold_n_nxt = hold_n_r;
    own_nxt    = own_r;
    drv_nxt    = 1'b0;
    lad_nxt    = lad_r;
    stb_n_nxt  = 1'b1;
    emu_nxt    = bus.local_clock_primary && !bus.shared_ack_out_n && st_r != MS_OWN;
    unique case (st_r)
      MS_IDLE: begin
        if (want_bus_i) begin
          hold_n_nxt = 1'b0;
          st_nxt     = MS_REQ;
        end
      end
      MS_REQ: begin
        if (!want_bus_i) begin
          hold_n_nxt = 1'b1;
          st_nxt     = MS_IDLE;
        end else if (ack_q34) begin
          own_nxt = 1'b1;
          st_nxt  = MS_OWN;
        end
      end
      MS_OWN: begin
        if (want_bus_i) begin
          drv_nxt   = 1'b1;
          lad_nxt   = own_data_i;
          stb_n_nxt = !own_strobe_i;
        end else begin
          own_nxt = 1'b0;
          st_nxt  = MS_REL;
        end
      end
      MS_REL: begin
        // drivers went off last cycle, so the request can now drop
        hold_n_nxt = 1'b1;
        // a q3-q4 low left over from this tenure must not start the next one
        if (hold_n_r && !bus.local_clock_primary && bus.shared_ack_out_n) begin
          st_nxt = MS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      st_r     <= MS_IDLE;
      hold_n_r <= `LBH_HOLD_RST;
      own_r    <= 1'b0;
      drv_r    <= 1'b0;
      lad_r    <= `LBH_LAD_RST;
      stb_n_r  <= `LBH_STROBE_RST;
      emu_r    <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      hold_n_r <= hold_n_nxt;
      own_r    <= own_nxt;
      drv_r    <= drv_nxt;
      lad_r    <= lad_nxt;
      stb_n_r  <= stb_n_nxt;
      emu_r    <= emu_nxt;
    end
  end

  assign bus.hold_req_n    = hold_n_r;
  assign bus.lad_mst       = lad_r;
  assign bus.lad_mst_oe    = drv_r;
  assign bus.strobe_mst_n  = stb_n_r;
  assign bus.strobe_mst_oe = drv_r;
  assign owned_o           = own_r;
  assign emu_seen_o        = emu_r;
endmodule : lbh_master

// *** design/lbh_device.sv ***
// device end: bus release, shared grant/emulation acknowledge, emulation mode
`timescale 1ns/1ps
`include "lbh_defines.svh"
module lbh_device #(
  parameter int unsigned PHASE_DIV = `LBH_PHASE_DIV, // core cycles per phase
  parameter int unsigned MEM_CYC   = `LBH_MEM_CYC    // core cycles per memory cycle
) (
  input  wire logic                   core_clk_i,           // 40 MHz clock
  input  wire logic                   rst_b_i,              // sync reset, low
  lbh_if.dev                          bus,                  // link to the master
  input  wire logic                   mem_req_i,            // start a local memory cycle, pulse
  input  wire lbh_pkg::lbh_word_t     mem_addr_i,           // address for that cycle
  output logic                        mem_busy_o,           // cycle running or bus away
  output logic                        mem_done_o,           // cycle finished, pulse
  input  wire logic                   run_emulate_in_i,     // run/emulate pin level
  input  wire logic                   run_emulate_oe_i,     // run/emulate pin driven
  input  wire logic                   emu_opcode_i,         // emulation opcode executed, pulse
  input  wire logic                   reset_pin_n_i,        // reset pin
  input  wire logic                   local_irq_first_n_i,  // interrupt pin 1
  input  wire logic                   local_irq_second_n_i, // interrupt pin 2
  input  wire logic                   hsync_i,              // horizontal sync pin
  input  wire logic                   vsync_i,              // vertical sync pin
  output logic                        emu_mode_o,           // emulation mode active
  output logic                        halted_o,             // halted for emulation
  output logic                        granted_o,            // bus handed to master
  output logic                        reset_req_o,          // normal reset request
  output logic [1:0]                  irq_req_o,            // normal interrupt requests
  output lbh_pkg::lbh_tpins_t         test_pins_o           // pins seen in emulation/test
);
  import lbh_pkg::*;

  localparam logic [7:0] DIV_LAST = 8'(PHASE_DIV - 1);
  localparam logic [7:0] CYC_LAST = 8'(MEM_CYC - 1);

  function automatic lbh_phase_t phase_after(input lbh_phase_t p);
    unique case (p)
      PH_Q1: phase_after = PH_Q2;
      PH_Q2: phase_after = PH_Q3;
      PH_Q3: phase_after = PH_Q4;
      default: phase_after = PH_Q1;
    endcase
  endfunction : phase_after

  function automatic logic in_q34(input lbh_phase_t p);
    in_q34 = (p == PH_Q3) || (p == PH_Q4);
  endfunction : in_q34

  // phase divider and local clocks
  logic [7:0]  div_r, div_nxt;
  lbh_phase_t  ph_r, ph_nxt;
  logic        local_clock_primary_r, local_clock_primary_nxt;
  logic        lclk2_r, lclk2_nxt;
  logic        ph_en;

  assign ph_en = (div_r == DIV_LAST);

  always_comb begin
    div_nxt   = ph_en ? 8'h00 : div_r + 8'h01;
    ph_nxt    = ph_en ? phase_after(ph_r) : ph_r;
    local_clock_primary_nxt = (ph_nxt == PH_Q1) || (ph_nxt == PH_Q2);
    lclk2_nxt = (ph_nxt == PH_Q2) || (ph_nxt == PH_Q3);
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      div_r   <= 8'h00;
      ph_r    <= PH_Q4;
      local_clock_primary_r <= 1'b0;
      lclk2_r <= 1'b0;
    end else begin
      div_r   <= div_nxt;
      ph_r    <= ph_nxt;
      local_clock_primary_r <= local_clock_primary_nxt;
      lclk2_r <= lclk2_nxt;
    end
  end

  // emulation mode, halt and pin reassignment
  logic       run_eff;
  logic       emu_r, emu_nxt;
  logic       halt_r, halt_nxt;
  logic       rst_req_r, rst_req_nxt;
  logic [1:0] irq_r, irq_nxt;
  lbh_tpins_t tp_r, tp_nxt;
  logic       cyc_act;

  // an undriven pin reads as run, so normal boards may leave it open
  assign run_eff = run_emulate_oe_i ? run_emulate_in_i : 1'b1;

  always_comb begin
    emu_nxt     = !run_eff;
    // halt waits for the running memory cycle so the bus is left clean
    halt_nxt    = emu_r && (halt_r || !cyc_act);
    rst_req_nxt = 1'b0;
    irq_nxt     = 2'b00;
    tp_nxt      = '0;
    if (emu_r) begin
      tp_nxt[`LBH_TP_RESET] = reset_pin_n_i;
      tp_nxt[`LBH_TP_IRQ1]  = local_irq_first_n_i;
      tp_nxt[`LBH_TP_IRQ2]  = local_irq_second_n_i;
      tp_nxt[`LBH_TP_HSYNC] = hsync_i;
      tp_nxt[`LBH_TP_VSYNC] = vsync_i;
    end else begin
      rst_req_nxt = !reset_pin_n_i;
      irq_nxt     = {!local_irq_second_n_i, !local_irq_first_n_i};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      emu_r     <= 1'b0;
      halt_r    <= 1'b0;
      rst_req_r <= 1'b0;
      irq_r     <= 2'b00;
      tp_r      <= '0;
    end else begin
      emu_r     <= emu_nxt;
      halt_r    <= halt_nxt;
      rst_req_r <= rst_req_nxt;
      irq_r     <= irq_nxt;
      tp_r      <= tp_nxt;
    end
  end

  // bus ownership and local memory cycles
  lbh_dstate_t st_r, st_nxt;
  logic [7:0]  cyc_r, cyc_nxt;
  logic        act_r, act_nxt;
  lbh_word_t   lad_r, lad_nxt;
  logic        done_r, done_nxt;
  logic        busy_r, busy_nxt;
  logic        gnt_r, gnt_nxt;
  logic        stb_n_r, stb_n_nxt;

  assign cyc_act = act_r;

  always_comb begin
    st_nxt   = st_r;
    cyc_nxt  = cyc_r;
    act_nxt  = act_r;
    lad_nxt  = lad_r;
    done_nxt = 1'b0;
    if (act_r) begin
      if (cyc_r == CYC_LAST) begin
        act_nxt  = 1'b0;
        done_nxt = 1'b1;
        cyc_nxt  = 8'h00;
      end else begin
        cyc_nxt = cyc_r + 8'h01;
      end
    end
    unique case (st_r)
      DS_OWN: begin
        // a pending request beats a new memory cycle
        if (!bus.hold_req_n && !act_r) begin
          st_nxt = DS_REL;
        end else if (mem_req_i && !act_r && !halt_r && bus.hold_req_n) begin
          act_nxt = 1'b1;
          cyc_nxt = 8'h00;
          lad_nxt = mem_addr_i;
        end
      end
      DS_REL: begin
        // drivers are already off here; grant follows the release
        st_nxt = bus.hold_req_n ? DS_OWN : DS_GRANT;
      end
      DS_GRANT: begin
        if (bus.hold_req_n) begin
          st_nxt = DS_OWN;
        end
      end
    endcase
    busy_nxt = act_nxt || (st_nxt != DS_OWN);
    gnt_nxt  = (st_nxt == DS_GRANT);
    stb_n_nxt = !act_nxt;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      st_r   <= DS_OWN;
      cyc_r  <= 8'h00;
      act_r  <= 1'b0;
      lad_r  <= `LBH_LAD_RST;
      done_r <= 1'b0;
      busy_r <= 1'b0;
      gnt_r  <= 1'b0;
      stb_n_r <= `LBH_STROBE_RST;
    end else begin
      st_r   <= st_nxt;
      cyc_r  <= cyc_nxt;
      act_r  <= act_nxt;
      lad_r  <= lad_nxt;
      done_r <= done_nxt;
      busy_r <= busy_nxt;
      gnt_r  <= gnt_nxt;
      stb_n_r <= stb_n_nxt;
    end
  end

  // shared acknowledge, timed to the phase being entered
  logic opc_pend_r, opc_pend_nxt;
  logic opc_act_r, opc_act_nxt;
  logic ack_r, ack_nxt;

  always_comb begin
    opc_pend_nxt = opc_pend_r || emu_opcode_i;
    opc_act_nxt  = opc_act_r;
    ack_nxt      = ack_r;
    if (ph_en) begin
      if (ph_nxt == PH_Q1) begin
        // opcodes pending at q1 entry share one q1-q2 window; a later opcode waits for the next cycle
        opc_act_nxt  = opc_pend_r;
        opc_pend_nxt = emu_opcode_i;
      end else if (ph_nxt == PH_Q3) begin
        opc_act_nxt = 1'b0;
      end
      if (in_q34(ph_nxt)) begin
        ack_nxt = (st_r != DS_GRANT);
      end else begin
        ack_nxt = !(halt_r || opc_act_nxt);
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      opc_pend_r <= 1'b0;
      opc_act_r  <= 1'b0;
      ack_r      <= `LBH_ACK_RST;
    end else begin
      opc_pend_r <= opc_pend_nxt;
      opc_act_r  <= opc_act_nxt;
      ack_r      <= ack_nxt;
    end
  end

  assign bus.shared_ack_out_n    = ack_r;
  assign bus.local_clock_primary = local_clock_primary_r;
  assign bus.local_clock_second  = lclk2_r;
  assign bus.lad_dev             = lad_r;
  assign bus.lad_dev_oe          = act_r;
  assign bus.strobe_dev_n        = stb_n_r;
  assign bus.strobe_dev_oe       = act_r;
  assign mem_busy_o              = busy_r;
  assign mem_done_o              = done_r;
  assign emu_mode_o              = emu_r;
  assign halted_o                = halt_r;
  assign granted_o               = gnt_r;
  assign reset_req_o             = rst_req_r;
  assign irq_req_o               = irq_r;
  assign test_pins_o             = tp_r;
endmodule : lbh_device

// *** sim/lbh_props.sv ***
// concurrent checks on the pins between the device end and the master end
`timescale 1ns/1ps
module lbh_props (
  input wire logic core_clk_i,          // core clock
  input wire logic rst_b_i,             // sync reset, low
  input wire logic hold_req_n,          // bus request, low
  input wire logic shared_ack_out_n,    // grant or emulation ack
  input wire logic local_clock_primary, // high in q1-q2
  input wire logic local_clock_second,  // high in q2-q3
  input wire logic lad_dev_oe,          // device drives lad
  input wire logic strobe_dev_oe,       // device drives strobe
  input wire logic lad_mst_oe           // master drives lad
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  logic q1;
  logic q2;
  logic q3;
  logic q4;
  logic grant_seen;
  assign q1 = local_clock_primary & ~local_clock_second;
  assign q2 = local_clock_primary & local_clock_second;
  assign q3 = ~local_clock_primary & local_clock_second;
  assign q4 = ~local_clock_primary & ~local_clock_second;
  // a low only counts as a grant outside q1-q2
  assign grant_seen = ~local_clock_primary & ~shared_ack_out_n;
  sequence s_quarter_walk;
    q2 ##1 q3 ##1 q4 ##1 q1;
  endsequence
  sequence s_held_grant;
    q4 && grant_seen && !hold_req_n ##1 !hold_req_n [*3];
  endsequence
  AST_PHASE_ORDER: assert property (q1 |=> s_quarter_walk)
    else $error("phases out of order");
  AST_GRANT_NEEDS_REQ: assert property (grant_seen |-> !$past(hold_req_n) || !$past(hold_req_n, 2))
    else $error("grant without request");
  AST_GRANT_AFTER_RELEASE: assert property (grant_seen |-> !lad_dev_oe && !strobe_dev_oe)
    else $error("grant while device drives bus");
  AST_GRANT_REPEATS: assert property (s_held_grant |-> grant_seen)
    else $error("grant not repeated");
  AST_GRANT_BOUND: assert property ($fell(hold_req_n) |-> ##[1:14] (hold_req_n || grant_seen))
    else $error("grant too late");
  AST_MST_HOLDS_REQ: assert property (lad_mst_oe |-> !hold_req_n)
    else $error("master drives without request");
  AST_NO_CONTENTION: assert property (lad_mst_oe |-> !lad_dev_oe)
    else $error("both ends drive lad");
  AST_MST_WAITS: assert property ($rose(lad_mst_oe) |-> $past(grant_seen, 2) || $past(grant_seen, 3))
    else $error("master took bus before grant");
endmodule : lbh_props

// *** sim/tb_top.sv ***
// self-checking bench joining device end and master end
`timescale 1ns/1ps
module tb_top;
  import lbh_pkg::*;
  typedef struct packed {
    logic       drv;
    logic       run;
    lbh_tpins_t pins;
    logic       e_emu;
    lbh_tpins_t e_tp;
    logic [1:0] e_irq;
    logic       e_rst;
  } lbh_row_t;
  localparam int NROW = 7;
  // pins are {vsync, hsync, irq2, irq1, reset}
  localparam lbh_row_t ROWS [NROW] = '{
    '{1'h0, 1'h0, 5'h00, 1'h0, 5'h00, 2'h3, 1'h1},
    '{1'h1, 1'h1, 5'h1f, 1'h0, 5'h00, 2'h0, 1'h0},
    '{1'h1, 1'h1, 5'h19, 1'h0, 5'h00, 2'h3, 1'h0},
    '{1'h1, 1'h1, 5'h1a, 1'h0, 5'h00, 2'h2, 1'h1},
    '{1'h1, 1'h0, 5'h15, 1'h1, 5'h15, 2'h0, 1'h0},
    '{1'h1, 1'h0, 5'h0a, 1'h1, 5'h0a, 2'h0, 1'h0},
    '{1'h1, 1'h1, 5'h1f, 1'h0, 5'h00, 2'h0, 1'h0}};
  logic       core_clk_i;
  logic       rst_b_i;
  logic       want_bus;
  logic       own_strobe;
  logic       mem_req;
  logic       emu_opc;
  logic       run_in;
  logic       run_oe;
  logic       owned;
  logic       emu_seen;
  logic       mem_busy;
  logic       mem_done;
  logic       emu_mode;
  logic       halted;
  logic       granted;
  logic       reset_req;
  logic       own_any;
  logic [1:0] irq_req;
  lbh_word_t  own_data;
  lbh_word_t  mem_addr;
  lbh_tpins_t pins;
  lbh_tpins_t tp;
  int         i;
  int         lows;
  int         seen;
  int         cycles;
  int         err_count;
  int         checks_done;
  lbh_if lbh_bus ();
  lbh_master u_lbh_master (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .bus(lbh_bus), .want_bus_i(want_bus),
    .own_data_i(own_data), .own_strobe_i(own_strobe), .owned_o(owned), .emu_seen_o(emu_seen));
  lbh_device u_lbh_device (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .bus(lbh_bus), .mem_req_i(mem_req),
    .mem_addr_i(mem_addr), .mem_busy_o(mem_busy), .mem_done_o(mem_done), .run_emulate_in_i(run_in),
    .run_emulate_oe_i(run_oe), .emu_opcode_i(emu_opc), .reset_pin_n_i(pins[0]), .local_irq_first_n_i(pins[1]),
    .local_irq_second_n_i(pins[2]), .hsync_i(pins[3]), .vsync_i(pins[4]), .emu_mode_o(emu_mode),
    .halted_o(halted), .granted_o(granted), .reset_req_o(reset_req), .irq_req_o(irq_req), .test_pins_o(tp));
  lbh_props u_lbh_props (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .hold_req_n(lbh_bus.hold_req_n),
    .shared_ack_out_n(lbh_bus.shared_ack_out_n), .local_clock_primary(lbh_bus.local_clock_primary),
    .local_clock_second(lbh_bus.local_clock_second), .lad_dev_oe(lbh_bus.lad_dev_oe),
    .strobe_dev_oe(lbh_bus.strobe_dev_oe), .lad_mst_oe(lbh_bus.lad_mst_oe));
  task automatic print_verdict();
    if (err_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [15:0] seen_v, input logic [15:0] exp_v);
    checks_done++;
    if (seen_v !== exp_v) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
    end
  endtask : chk
  task automatic wait_ph(input logic p, input logic s);
    for (int k = 0; k < 8 && !(lbh_bus.local_clock_primary === p && lbh_bus.local_clock_second === s); k++) begin
      @(negedge core_clk_i);
    end
  endtask : wait_ph
  initial begin
    core_clk_i = 1'h0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  // whole run is under two hundred cycles; ceiling leaves wide margin
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    {rst_b_i, want_bus, own_strobe, mem_req, emu_opc, run_in, run_oe, own_any} = 8'h00;
    {own_data, mem_addr, pins, cycles, err_count, checks_done} = '0;
    repeat (20) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk(16'(lbh_bus.shared_ack_out_n), 16'h1);
    @(posedge core_clk_i) rst_b_i <= 1'h1;
    for (i = 0; i < NROW; i++) begin
      @(posedge core_clk_i);
      run_oe <= ROWS[i].drv;
      run_in <= ROWS[i].run;
      pins   <= ROWS[i].pins;
      repeat (4) @(negedge core_clk_i);
      chk(16'(emu_mode), 16'(ROWS[i].e_emu));
      chk(16'(halted), 16'(ROWS[i].e_emu));
      chk(16'(tp), 16'(ROWS[i].e_tp));
      chk(16'({reset_req, irq_req}), 16'({ROWS[i].e_rst, ROWS[i].e_irq}));
      if (ROWS[i].e_emu) begin
        wait_ph(1'h1, 1'h0);
        chk(16'(lbh_bus.shared_ack_out_n), 16'h0);
        wait_ph(1'h0, 1'h1);
        chk(16'(lbh_bus.shared_ack_out_n), 16'h1);
      end
    end
    // request lands while a memory cycle is running
    @(posedge core_clk_i);
    mem_req  <= 1'h1;
    mem_addr <= 16'h1234;
    @(posedge core_clk_i);
    mem_req    <= 1'h0;
    want_bus   <= 1'h1;
    own_strobe <= 1'h1;
    own_data   <= 16'ha5c3;
    for (i = 0; i < 20 && owned !== 1'h1; i++) @(negedge core_clk_i);
    chk(16'({owned, granted}), 16'h3);
    @(posedge core_clk_i) mem_req <= 1'h1;
    for (i = 0; i < 8; i++) begin
      @(negedge core_clk_i);
      if (!lbh_bus.local_clock_primary) chk(16'(lbh_bus.shared_ack_out_n), 16'h0);
      else chk(16'(lbh_bus.shared_ack_out_n), 16'h1);
      chk(16'({mem_done, mem_busy}), 16'h1);
      chk(16'(lbh_bus.hold_req_n), 16'h0);
    end
    chk(lbh_bus.lad_bus, 16'ha5c3);
    @(posedge core_clk_i);
    mem_req  <= 1'h0;
    want_bus <= 1'h0;
    for (i = 0; i < 12 && granted !== 1'h0; i++) @(negedge core_clk_i);
    chk(16'(granted), 16'h0);
    repeat (2) @(negedge core_clk_i);
    for (i = 0; i < 4; i++) begin
      @(negedge core_clk_i);
      if (!lbh_bus.local_clock_primary) chk(16'(lbh_bus.shared_ack_out_n), 16'h1);
    end
    @(posedge core_clk_i) mem_req <= 1'h1;
    @(posedge core_clk_i) mem_req <= 1'h0;
    @(negedge core_clk_i);
    chk(lbh_bus.lad_bus, 16'h1234);
    for (i = 0; i < 10 && mem_done !== 1'h1; i++) @(negedge core_clk_i);
    chk(16'({mem_done, mem_busy}), 16'h2);
    // one opcode: q1-q2 low once, never mistaken for a grant
    @(posedge core_clk_i) emu_opc <= 1'h1;
    @(posedge core_clk_i) emu_opc <= 1'h0;
    lows = 0;
    seen = 0;
    for (i = 0; i < 12; i++) begin
      @(negedge core_clk_i);
      if (lbh_bus.shared_ack_out_n === 1'h0) lows += lbh_bus.local_clock_primary ? 1 : 16;
      seen += int'(emu_seen);
      own_any |= owned;
    end
    chk(16'(lows), 16'h2);
    chk(16'(seen != 0), 16'h1);
    chk(16'(own_any), 16'h0);
    // reset in mid tenure: both ends drop the bus, then a fresh request is served
    @(posedge core_clk_i) want_bus <= 1'h1;
    for (i = 0; i < 20 && owned !== 1'h1; i++) @(negedge core_clk_i);
    @(posedge core_clk_i) rst_b_i <= 1'h0;
    repeat (2) @(negedge core_clk_i);
    chk(16'({owned, granted, lbh_bus.lad_mst_oe, lbh_bus.hold_req_n, lbh_bus.shared_ack_out_n}), 16'h3);
    @(posedge core_clk_i) rst_b_i <= 1'h1;
    for (i = 0; i < 20 && owned !== 1'h1; i++) @(negedge core_clk_i);
    chk(16'({owned, granted, lbh_bus.hold_req_n}), 16'h6);
    print_verdict();
  end
endmodule : tb_top
